// file: hw/mid_pkg.sv
// constants, types and register map of the instruction decode and execution core
package mid_pkg;
   // instruction word and program counter widths, option period bit and cycle lengths
   localparam int unsigned INSTR_W      = 13;
   localparam int unsigned PC_W         = 12;
   localparam int unsigned OPT_PERIOD_BIT = 10;
   localparam int unsigned PERIOD_SHORT = 2;
   localparam int unsigned PERIOD_LONG  = 4;
   // register designators with a fixed meaning
   localparam logic [5:0]  IDX_PC       = 6'h02;
   localparam logic [5:0]  IDX_STATUS   = 6'h03;
   localparam logic [5:0]  IDX_IRQ_STAT = 6'h0f;
   // fixed control-group codes
   localparam logic [12:0] OP_NOP       = 13'h0000;
   localparam logic [12:0] OP_DEC_ADJ   = 13'h0001;
   localparam logic [12:0] OP_CONT_WR   = 13'h0002;
   localparam logic [12:0] OP_SLEEP     = 13'h0003;
   localparam logic [12:0] OP_WDOG_CLR  = 13'h0004;
   localparam logic [12:0] OP_IRQ_EN    = 13'h0010;
   localparam logic [12:0] OP_IRQ_DIS   = 13'h0011;
   localparam logic [12:0] OP_RET       = 13'h0012;
   localparam logic [12:0] OP_RET_IRQ   = 13'h0013;
   localparam logic [12:0] OP_CONT_RD   = 13'h0014;
   localparam logic [12:0] OP_TABLE     = 13'h0020;
   localparam logic [12:0] OP_CLR_ACC   = 13'h0080;
   localparam logic [12:0] OP_SOFT_INT  = 13'h1e01;
   localparam logic [PC_W-1:0] SOFT_INT_VEC = 12'h001;
   // apb register byte offsets, status reset value and BCD_LOW_MAX
   localparam logic [7:0]  OFS_CTRL     = 8'h00;
   localparam logic [7:0]  OFS_STATE    = 8'h04;
   localparam logic [7:0]  OFS_OPTION   = 8'h08;
   localparam logic [7:0]  OFS_MISC     = 8'h0c;
   localparam logic [7:0]  STATUS_RST   = 8'h18;
   localparam logic [2:0]  BCD_LOW_MAX  = 3'h0;

   // status register byte: page, timeout, powerdown, zero, digit carry, carry
   typedef struct packed {
      logic       rsv;
      logic [1:0] page;
      logic       t;
      logic       p;
      logic       z;
      logic       dc;
      logic       c;
   } mid_status_t;

   typedef enum logic [2:0] {
      ST_EXEC  = 3'b001,
      ST_STALL = 3'b010,
      ST_SLEEP = 3'b100
   } mid_state_t;
endpackage

// file: hw/mid_core.sv
// instruction decode and execution core with apb control window
`timescale 1ns/1ps
module mid_core
   import mid_pkg::*;
#(
   parameter int unsigned STACK_DEPTH = 8,   // return stack entries
   parameter bit          ALT_TIMING  = 1'b0 // two-cycle branches and taken skips
) (
   input  wire logic               clk,         // oscillator clock
   input  wire logic               reset_n,     // async reset, active low
   input  wire logic               psel,        // apb select
   input  wire logic               penable,     // apb access phase
   input  wire logic               pwrite,      // apb write
   input  wire logic [7:0]         paddr,       // apb byte address
   input  wire logic [31:0]        pwdata,      // apb write data
   output logic      [31:0]        prdata,      // apb read data
   output logic                    pready,      // apb ready
   output logic                    pslverr,     // apb error on unmapped address
   output logic      [PC_W-1:0]    imem_addr,   // program memory address
   input  wire logic [INSTR_W-1:0] imem_data,   // instruction at imem_addr
   input  wire logic [INSTR_W-1:0] option_word, // one-time option word
   input  wire logic               wake,        // leave sleep
   output logic                    wdt_clear,   // watchdog clear pulse
   output logic                    osc_stop,    // oscillator stopped
   output logic                    irq_enable,  // interrupts enabled
   output logic                    timer_tick   // timer clock enable pulse
);
   initial begin
      if (STACK_DEPTH < 2 || STACK_DEPTH > 16) $error("STACK_DEPTH must be 2 to 16");
   end
   localparam int unsigned SP_W = $clog2(STACK_DEPTH);

   mid_state_t         st_q;
   mid_status_t        stat_q;
   logic [PC_W-1:0]    pc_q;
   logic [7:0]         acc_q, cont_q;
   logic [7:0]         rf_q [64];
   logic [7:0]         iocr_q [16];
   logic [PC_W-1:0]    stk_q [STACK_DEPTH];
   logic [SP_W-1:0]    sp_q;
   logic               skip_q, irq_en_q, run_q, opt_valid_q, period_sel_q, wdt_clr_q;
   logic [1:0]         div_q;
   logic [INSTR_W-1:0] opt_q;

   ////////////////////////////////////////////////////////////////////////////
   // option capture and instruction cycle divider
   // option bit is latched once after reset release; a strap is never reset data
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         opt_valid_q  <= 1'b0;
         period_sel_q <= 1'b0;
         opt_q        <= '0;
      end else if (!opt_valid_q) begin
         opt_valid_q  <= 1'b1;
         period_sel_q <= option_word[OPT_PERIOD_BIT];
         opt_q        <= option_word;
      end
   end

   wire       osc_run  = (st_q != ST_SLEEP) && opt_valid_q;
   wire [1:0] div_last = period_sel_q ? 2'(PERIOD_LONG - 1) : 2'(PERIOD_SHORT - 1);
   wire       cyc_en   = osc_run && (div_q == div_last);

   // divider clears to zero while the oscillator is stopped
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) div_q <= 2'h0;
      else if (!osc_run) div_q <= 2'h0;
      else if (cyc_en) div_q <= 2'h0;
      else div_q <= div_q + 2'h1;
   end
   assign timer_tick = cyc_en;

   ////////////////////////////////////////////////////////////////////////////
   // instruction fields and decode
   wire [12:0] ins   = imem_data;
   wire [5:0]  r_idx = ins[5:0];
   wire [2:0]  b_idx = ins[8:6];
   wire [7:0]  k8    = ins[7:0];
   wire        to_r  = ins[6];
   wire        is_reg   = !ins[12] && !ins[11] && (ins[10:8] != 3'h0);
   wire        is_bit   = !ins[12] && ins[11];
   wire        is_call  = ins[12:10] == 3'b100;
   wire        is_jmp   = ins[12:10] == 3'b101;
   wire        is_lit   = ins[12:11] == 2'b11;
   wire        is_mov_r = ins[12:6] == 7'h01;
   wire        is_clr_r = ins[12:6] == 7'h03;
   wire        is_iow   = ins[12:4] == 9'h000 && ins[3:0] > 4'h4;
   wire        is_ior   = ins[12:4] == 9'h001 && ins[3:0] > 4'h4;
   wire        ioc_ok   = (ins[3:0] inside {4'h5, 4'h6}) || ins[3:0] >= 4'hb;
   wire        is_ret   = (ins == OP_RET) || (ins == OP_RET_IRQ) || (is_lit && ins[10:8] == 3'h4);
   wire        lit_sub  = is_lit && ins[10:8] == 3'h5;
   wire        reg_sub  = is_reg && ins[10:7] == 4'h2;

   // register read: program counter and status are live views
   wire [7:0] rd = (r_idx == IDX_PC) ? pc_q[7:0] : (r_idx == IDX_STATUS) ? stat_q : rf_q[r_idx];

   // shared adder: subtract forms feed the inverted accumulator
   wire [7:0] add_a  = (ins == OP_TABLE) ? pc_q[7:0] : is_lit ? k8 : rd;
   wire [7:0] add_b  = (reg_sub || lit_sub) ? ~acc_q : acc_q;
   wire       add_ci = reg_sub || lit_sub;
   wire [8:0] sum9   = {1'b0, add_a} + {1'b0, add_b} + {8'h00, add_ci};
   wire [4:0] nib5   = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_ci};

   // decimal adjust corrections
   wire       bcd_lo  = stat_q.dc || (acc_q[3:0] > 4'h9);
   wire       bcd_hi  = stat_q.c || (acc_q > 8'h99);
   wire [8:0] bcd9    = {1'b0, acc_q} + {1'b0, bcd_hi ? 8'h60 : 8'h00} + {5'h00, bcd_lo ? 4'h6 : 4'h0};

   ////////////////////////////////////////////////////////////////////////////
   // execution datapath
   logic [7:0] res;
   logic       wr_a, wr_r, upd_z, upd_cdc, set_c, c_new, skip_take, known;
   always_comb begin
      res = rd; wr_a = 1'b0; wr_r = 1'b0; upd_z = 1'b0; upd_cdc = 1'b0;
      set_c = 1'b0; c_new = stat_q.c; skip_take = 1'b0; known = 1'b1;
      if (is_reg) begin
         wr_a = !to_r;
         wr_r = to_r;
         upd_z = 1'b1;
         case ({ins[10:8], ins[7]})
            4'h2, 4'h7: begin res = sum9[7:0]; upd_cdc = 1'b1; end
            4'h3: res = rd - 8'h01;
            4'h4: res = acc_q | rd;
            4'h5: res = acc_q & rd;
            4'h6: res = acc_q ^ rd;
            4'h8: res = rd;
            4'h9: res = ~rd;
            4'ha: res = rd + 8'h01;
            4'hb: begin res = rd - 8'h01; upd_z = 1'b0; skip_take = (res == 8'h00); end
            4'hc: begin res = {stat_q.c, rd[7:1]}; upd_z = 1'b0; set_c = 1'b1; c_new = rd[0]; end
            4'hd: begin res = {rd[6:0], stat_q.c}; upd_z = 1'b0; set_c = 1'b1; c_new = rd[7]; end
            4'he: begin res = {rd[3:0], rd[7:4]}; upd_z = 1'b0; end
            4'hf: begin res = rd + 8'h01; upd_z = 1'b0; skip_take = (res == 8'h00); end
            default: begin wr_a = 1'b0; wr_r = 1'b0; upd_z = 1'b0; end
         endcase
      end else if (is_bit) begin
         res = rd;
         case (ins[10:9])
            2'b00: begin res[b_idx] = 1'b0; wr_r = 1'b1; end
            2'b01: begin res[b_idx] = 1'b1; wr_r = 1'b1; end
            2'b10: skip_take = !rd[b_idx];
            default: skip_take = rd[b_idx];
         endcase
      end else if (is_lit) begin
         wr_a = 1'b1;
         upd_z = 1'b1;
         case (ins[10:8])
            3'h0: begin res = k8; upd_z = 1'b0; end
            3'h1: res = acc_q | k8;
            3'h2: res = acc_q & k8;
            3'h3: res = acc_q ^ k8;
            3'h4: begin res = k8; upd_z = 1'b0; end
            3'h5, 3'h7: begin res = sum9[7:0]; upd_cdc = 1'b1; end
            default: begin wr_a = 1'b0; upd_z = 1'b0; known = (ins == OP_SOFT_INT); end
         endcase
      end else if (is_mov_r) begin
         res = acc_q; wr_r = 1'b1;
      end else if (is_clr_r || ins == OP_CLR_ACC) begin
         res = 8'h00; wr_r = is_clr_r; wr_a = !is_clr_r; upd_z = 1'b1;
      end else if (ins == OP_DEC_ADJ) begin
         res = bcd9[7:0]; wr_a = 1'b1; set_c = 1'b1; c_new = stat_q.c || bcd9[8];
      end else if (ins == OP_TABLE) begin
         res = sum9[7:0]; upd_z = 1'b1; upd_cdc = 1'b1;
      end else if (is_ior && ioc_ok) begin
         res = iocr_q[ins[3:0]]; wr_a = 1'b1;
      end else if (ins == OP_CONT_RD) begin
         res = cont_q; wr_a = 1'b1;
      end else begin
         known = is_call || is_jmp || (is_iow && ioc_ok) || ins inside {OP_NOP, OP_CONT_WR,
                 OP_SLEEP, OP_WDOG_CLR, OP_IRQ_EN, OP_IRQ_DIS, OP_RET, OP_RET_IRQ};
      end
   end

   // program counter writes and the two-cycle decision
   wire pc_wr     = (wr_r && r_idx == IDX_PC) || (ins == OP_TABLE);
   wire branch    = is_call || is_jmp || is_ret || (ins == OP_SOFT_INT) || skip_take;
   wire two_cyc   = pc_wr || (ALT_TIMING && branch);
   wire ex_fire   = cyc_en && run_q && (st_q == ST_EXEC);
   wire ex_do     = ex_fire && !skip_q;
   wire [PC_W-1:0] pc_inc = pc_q + 12'h001;
   wire [SP_W-1:0] sp_top = sp_q - SP_W'(1);

   ////////////////////////////////////////////////////////////////////////////
   // state sequencing: stall for two-cycle instructions, sleep until wake
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) st_q <= ST_EXEC;
      else begin
         case (st_q)
            ST_EXEC:  if (ex_do && ins == OP_SLEEP) st_q <= ST_SLEEP;
                      else if (ex_do && two_cyc) st_q <= ST_STALL;
            ST_STALL: if (cyc_en) st_q <= ST_EXEC;
            ST_SLEEP: if (wake) st_q <= ST_EXEC;
            default:  st_q <= ST_EXEC;
         endcase
      end
   end

   // program counter, stack and skip
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pc_q <= '0; sp_q <= '0; skip_q <= 1'b0;
      end else if (ex_fire) begin
         skip_q <= ex_do && skip_take;
         pc_q   <= pc_inc;
         if (ex_do) begin
            if (is_call || ins == OP_SOFT_INT) begin
               stk_q[sp_q] <= pc_inc;
               sp_q        <= sp_q + SP_W'(1);
            end
            if (is_call || is_jmp) pc_q <= {stat_q.page, ins[9:0]};
            else if (ins == OP_SOFT_INT) pc_q <= SOFT_INT_VEC;
            else if (is_ret) begin
               pc_q <= stk_q[sp_top];
               sp_q <= sp_top;
            end
            else if (ins == OP_TABLE) pc_q <= {pc_q[11:8], sum9[7:0]};
            else if (pc_wr) pc_q <= {pc_q[11:10], 2'b00, res};
         end
      end
   end

   // accumulator, status and register files
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_q <= 8'h00; cont_q <= 8'h00; stat_q <= STATUS_RST; irq_en_q <= 1'b0;
         for (int i = 0; i < 64; i++) rf_q[i] <= 8'h00;
         for (int i = 0; i < 16; i++) iocr_q[i] <= 8'h00;
      end else if (ex_do) begin
         if (wr_a) acc_q <= res;
         if (wr_r && r_idx == IDX_STATUS) begin
            stat_q.page <= res[6:5]; stat_q.z <= res[2]; stat_q.dc <= res[1]; stat_q.c <= res[0];
         end else if (wr_r && r_idx != IDX_PC) rf_q[r_idx] <= res;
         if (upd_z) stat_q.z <= (res == 8'h00);
         if (upd_cdc) begin
            stat_q.c  <= sum9[8];
            stat_q.dc <= nib5[4];
         end
         if (set_c) stat_q.c <= c_new;
         if (ins == OP_SLEEP) begin stat_q.t <= 1'b1; stat_q.p <= 1'b0; end
         if (ins == OP_WDOG_CLR) begin stat_q.t <= 1'b1; stat_q.p <= 1'b1; end
         if (ins == OP_IRQ_EN || ins == OP_RET_IRQ) irq_en_q <= 1'b1;
         if (ins == OP_IRQ_DIS) irq_en_q <= 1'b0;
         if (is_iow && ioc_ok) iocr_q[ins[3:0]] <= acc_q;
         if (ins == OP_CONT_WR) cont_q <= acc_q;
      end
   end

   // watchdog clear pulse for both sleep and watchdog clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) wdt_clr_q <= 1'b0;
      else wdt_clr_q <= ex_do && (ins == OP_SLEEP || ins == OP_WDOG_CLR);
   end

   assign imem_addr  = pc_q;
   assign wdt_clear  = wdt_clr_q;
   assign osc_stop   = (st_q == ST_SLEEP);
   assign irq_enable = irq_en_q;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: zero wait states, read data captured in the setup cycle
   wire hit_ctrl  = paddr == OFS_CTRL;
   wire hit_state = paddr == OFS_STATE;
   wire hit_opt   = paddr == OFS_OPTION;
   wire hit_misc  = paddr == OFS_MISC;
   wire mapped    = hit_ctrl || hit_state || hit_opt || hit_misc;
   wire [31:0] rd_mux = hit_ctrl  ? {31'h0, run_q} :
                        hit_state ? {4'h0, pc_q, stat_q, acc_q} :
                        hit_opt   ? {19'h0, opt_q} :
                        hit_misc  ? {25'h0, st_q, skip_q, period_sel_q, irq_en_q, opt_valid_q} : 32'h0;

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= 32'h0; run_q <= 1'b0;
      end else begin
         if (psel && !penable && !pwrite) prdata <= rd_mux;
         if (psel && penable && pwrite && hit_ctrl) run_q <= pwdata[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_long_cycle;
      @(posedge clk) disable iff (!reset_n)
      cyc_en && period_sel_q && osc_run |=> !cyc_en [*3] ##1 (cyc_en || !osc_run);
   endproperty
   a_long_cycle: assert property (p_long_cycle) else $error("four-clock cycle spacing wrong");

   property p_short_cycle;
      @(posedge clk) disable iff (!reset_n)
      cyc_en && !period_sel_q && osc_run |=> !timer_tick ##1 (timer_tick || !osc_run);
   endproperty
   a_short_cycle: assert property (p_short_cycle) else $error("two-clock cycle spacing wrong");

   property p_pc_write_stall;
      @(posedge clk) disable iff (!reset_n)
      ex_do && pc_wr |=> st_q == ST_STALL;
   endproperty
   a_pc_write_stall: assert property (p_pc_write_stall) else $error("pc write did not stall");

   property p_call_push;
      @(posedge clk) disable iff (!reset_n)
      ex_do && is_call |=> sp_q == SP_W'($past(sp_q) + 1) && pc_q[9:0] == $past(ins[9:0]);
   endproperty
   a_call_push: assert property (p_call_push) else $error("call did not push and load");

   property p_soft_int;
      @(posedge clk) disable iff (!reset_n)
      ex_do && ins == OP_SOFT_INT |=> pc_q == SOFT_INT_VEC && stk_q[$past(sp_q)] == $past(pc_inc);
   endproperty
   a_soft_int: assert property (p_soft_int) else $error("soft interrupt vector wrong");

   property p_sleep;
      @(posedge clk) disable iff (!reset_n)
      ex_do && ins == OP_SLEEP |=> osc_stop && wdt_clear && !stat_q.p && stat_q.t;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep effects missing");

   property p_irq_enable;
      @(posedge clk) disable iff (!reset_n)
      ex_do && (ins == OP_IRQ_EN || ins == OP_RET_IRQ) |=> irq_enable;
   endproperty
   a_irq_enable: assert property (p_irq_enable) else $error("interrupts not enabled");

   property p_skip_discard;
      @(posedge clk) disable iff (!reset_n)
      ex_fire && skip_q |=> $stable(acc_q) && $stable(stat_q);
   endproperty
   a_skip_discard: assert property (p_skip_discard) else $error("skipped word had effect");

   property p_option_fixed;
      @(posedge clk) disable iff (!reset_n)
      opt_valid_q |=> $stable(period_sel_q);
   endproperty
   a_option_fixed: assert property (p_option_fixed) else $error("period select changed");

   property p_undefined_nop;
      @(posedge clk) disable iff (!reset_n)
      ex_do && !known |=> $stable(acc_q) && $stable(stat_q) && $stable(sp_q);
   endproperty
   a_undefined_nop: assert property (p_undefined_nop) else $error("undefined code changed state");
endmodule

// file: verification/mid_imem_model.sv
// program memory model feeding instruction words to the core
`timescale 1ns/1ps
module mid_imem_model
   import mid_pkg::*;
(
   input  wire logic [PC_W-1:0]    addr, // fetch address from core
   output logic      [INSTR_W-1:0] data  // instruction word at addr
);
   logic [INSTR_W-1:0] mem [0:15];
   ////////////////////////////////////////////////////////////////////////
   // start empty so stray fetches are harmless no-operations
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = OP_NOP;
   end
   // beyond the small store every fetch is a no-operation word
   assign data = (addr < 16) ? mem[addr[3:0]] : OP_NOP;
endmodule

// file: verification/mcu_instruction_decoder_tb.sv
// self-checking bench for the instruction decode core
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module mcu_instruction_decoder_tb;
   import mid_pkg::*;
   logic               clk, reset_n, psel, penable, pwrite, pready, pslverr, wake;
   logic               wdt_clear, osc_stop, irq_enable, timer_tick, err;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, q;
   logic [PC_W-1:0]    imem_addr;
   logic [INSTR_W-1:0] imem_data, opt;
   int                 bad_count, samples_checked, wdt_pulses, g;
   // arithmetic, skip and sleep program; no bit set on interrupt status
   logic [12:0] p1 [0:15] = '{13'h1805, 13'h0050, 13'h1f0b, 13'h0110, 13'h0710, 13'h05d0, 13'h0410,
      13'h1a00, 13'h0a50, 13'h0e90, 13'h18ff, 13'h0410, 13'h0004, 13'h0003, 13'h0030, 13'h0000};
   // skip-if-clear, call, return-literal, soft interrupt, then sleep on the second pass
   logic [12:0] p2 [0:15] = '{13'h0010, 13'h0c50, 13'h0003, 13'h1006, 13'h0a50, 13'h1e01, 13'h1c2a,
      13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0000};
   mid_core uut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .imem_addr(imem_addr), .imem_data(imem_data), .option_word(opt), .wake(wake),
      .wdt_clear(wdt_clear), .osc_stop(osc_stop), .irq_enable(irq_enable), .timer_tick(timer_tick));
   mid_imem_model u_mem (.addr(imem_addr), .data(imem_data));
   ////////////////////////////////////////////////////////////////////////
   // clock and watchdog-clear pulse counter
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) if (wdt_clear === 1'b1) wdt_pulses++;
   ////////////////////////////////////////////////////////////////////////
   // one apb transfer; request held until pready seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
      q = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // reset for six cycles and load the program; the core is left stopped until the control register is written
   task automatic restart(input int sel);
      reset_n <= 1'b0;
      for (int i = 0; i < 16; i++) u_mem.mem[i] = sel ? p2[i] : p1[i];
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      wdt_pulses = 0;
   endtask
   // clocks between two timer pulses; bounded so a dead divider cannot hang
   task automatic tick_gap();
      int n;
      n = 0;
      @(negedge clk);
      while (timer_tick !== 1'b1 && n < 100) begin @(negedge clk); n++; end
      g = 0;
      do begin @(negedge clk); g++; end while (timer_tick !== 1'b1 && g < 100);
   endtask
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      int n;
      psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      wake = 1'b0; opt = 13'h0000; reset_n = 1'b0; bad_count = 0; samples_checked = 0;
      restart(0);
      apb(1'b0, OFS_STATE, 32'h0);
      `CHK(q, {16'h0000, STATUS_RST, 8'h00})
      apb(1'b0, 8'h40, 32'h0);
      `CHK({q, err}, {32'h0, 1'b1})
      apb(1'b0, OFS_OPTION, 32'h0);
      `CHK(q[12:0], opt)
      apb(1'b1, OFS_CTRL, 32'h1);
      apb(1'b0, OFS_CTRL, 32'h0);
      `CHK(q[0], 1'b1)
      tick_gap();
      `CHK(g, PERIOD_SHORT)
      n = 0;
      while (osc_stop !== 1'b1 && n < 2000) begin @(posedge clk); n++; end
      apb(1'b0, OFS_STATE, 32'h0);
      `CHK(q[7:0], 8'h06)
      `CHK(q[10], 1'b0)
      `CHK(wdt_pulses, 2)
      apb(1'b0, OFS_MISC, 32'h0);
      `CHK(q[6:4], 3'h4)
      `CHK(q[2], 1'b0)
      wake <= 1'b1;
      n = 0;
      while (osc_stop !== 1'b0 && n < 200) begin @(posedge clk); n++; end
      `CHK(osc_stop, 1'b0)
      wake <= 1'b0;
      // unlisted word after wake must leave the accumulator alone
      repeat (20) @(posedge clk);
      apb(1'b0, OFS_STATE, 32'h0);
      `CHK(q[7:0], 8'h06)
      // long instruction cycle from option bit ten
      opt <= 13'h0400;
      restart(1);
      apb(1'b1, OFS_CTRL, 32'h1);
      apb(1'b0, OFS_MISC, 32'h0);
      `CHK(q[2], 1'b1)
      tick_gap();
      `CHK(g, PERIOD_LONG)
      n = 0;
      while (osc_stop !== 1'b1 && n < 2000) begin @(posedge clk); n++; end
      apb(1'b0, OFS_STATE, 32'h0);
      `CHK(q[7:0], 8'h2a)
      `CHK(q[27:16], 12'h003)
      `CHK(irq_enable, 1'b1)
      give_verdict();
   end
   // cuts a hang short well beyond the expected couple of hundred cycles
   initial begin
      #200000;
      bad_count++;
      give_verdict();
   end
endmodule
